// ===== cmpei_top.sv
// Comparator edge interrupt and input select block with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module cmpei_top
	import cmpei_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
	input  wire logic                  s_axi_awvalid_in,
	output logic                       s_axi_awready_out,
	input  wire logic [31:0]           s_axi_wdata_in,
	input  wire logic [3:0]            s_axi_wstrb_in,
	input  wire logic                  s_axi_wvalid_in,
	output logic                       s_axi_wready_out,
	output logic [1:0]                 s_axi_bresp_out,
	output logic                       s_axi_bvalid_out,
	input  wire logic                  s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
	input  wire logic                  s_axi_arvalid_in,
	output logic                       s_axi_arready_out,
	output logic [31:0]                s_axi_rdata_out,
	output logic [1:0]                 s_axi_rresp_out,
	output logic                       s_axi_rvalid_out,
	input  wire logic                  s_axi_rready_in,
	// Analogue side
	input  wire logic [NCMP-1:0]       cmp_raw_in,
	output logic [NCMP-1:0]            cmp_result_out,
	output logic [NCMP-1:0]            cmp_enable_out,
	output logic [NCMP-1:0][3:0]       pos_route_out,
	output logic [NCMP-1:0][2:0]       neg_sel_out,
	// Interrupt
	output logic                       irq_out
);
	cmpei_state_s r;
	cmpei_state_s n;

	cmpei_edge_if eif ();

	cmpei_edge u_edge (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.eif        (eif)
	);

	always_comb
	begin
		for (int i = 0; i < NCMP; i++)
		begin
			eif.rise_en[i] = r.ectl[i][ECTL_RISE_BIT];
			eif.fall_en[i] = r.ectl[i][ECTL_FALL_BIT];
		end
		eif.result = r.result;
	end

	always_comb
	begin
		logic [NCMP-1:0] clr;
		clr = '0;
		n = r;

		if (r.bvalid && s_axi_bready_in)
			n.bvalid = 1'b0;
		if (s_axi_awvalid_in && r.awready)
		begin
			n.aw_got = 1'b1;
			n.waddr  = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && r.wready)
		begin
			n.w_got = 1'b1;
			n.wbyte = s_axi_wdata_in[7:0];
			n.wlane = s_axi_wstrb_in[0];
		end

		// Address and data may arrive in either order; the write waits for a free response slot
		if (n.aw_got && n.w_got && !n.bvalid)
		begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			case (n.waddr)
				ADDR_MCTL1:
					if (n.wlane)
						n.mctl[0] = n.wbyte & MCTL_WMASK;
				ADDR_MCTL2:
					if (n.wlane)
						n.mctl[1] = n.wbyte & MCTL_WMASK;
				ADDR_ECTL1:
					if (n.wlane)
						n.ectl[0] = n.wbyte & ECTL_WMASK;
				ADDR_ECTL2:
					if (n.wlane)
						n.ectl[1] = n.wbyte & ECTL_WMASK;
				// [R5] Mirror ignores writes
				ADDR_MIRROR: ;
				ADDR_IRQ_STAT:
					if (n.wlane)
						clr = n.wbyte[NCMP-1:0];
				ADDR_IRQ_MASK:
					if (n.wlane)
						n.mask = n.wbyte[NCMP-1:0];
				default:
					n.bresp = RESP_SLVERR;
			endcase
		end

		for (int i = 0; i < NCMP; i++)
		begin
			// [R9] Result follows enable and invert even when off
			n.result[i] = (n.mctl[i][MCTL_EN_BIT] & cmp_raw_in[i]) ^ n.mctl[i][MCTL_INV_BIT];
			// [R7] Positive input routing
			n.pos_route[i] = POS_ROUTE_ONE << n.ectl[i][POS_LSB +: 2];
		end

		// [R8] Set wins over clear
		n.flag = (r.flag & ~clr) | eif.edge_set;
		n.irq  = |(n.flag & n.mask);

		if (r.rvalid && s_axi_rready_in)
			n.rvalid = 1'b0;
		if (s_axi_arvalid_in && r.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = '0;
			case (s_axi_araddr_in)
				ADDR_MCTL1:
					n.rdata[7:0] = r.mctl[0] | ({7'h00, r.result[0]} << MCTL_RES_BIT);
				ADDR_MCTL2:
					n.rdata[7:0] = r.mctl[1] | ({7'h00, r.result[1]} << MCTL_RES_BIT);
				ADDR_ECTL1:
					n.rdata[7:0] = r.ectl[0];
				ADDR_ECTL2:
					n.rdata[7:0] = r.ectl[1];
				// [R3] [R4] [R5] Mirror bits, upper zero
				ADDR_MIRROR:
					n.rdata[NCMP-1:0] = r.result;
				ADDR_IRQ_STAT:
					n.rdata[NCMP-1:0] = r.flag;
				ADDR_IRQ_MASK:
					n.rdata[NCMP-1:0] = r.mask;
				default:
					n.rresp = RESP_SLVERR;
			endcase
		end

		// Ready is registered, so each channel takes at most one item per response
		n.awready = !n.aw_got;
		n.wready  = !n.w_got;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		// [R6] Results and mirror clear on reset
		if (rst_in)
		begin
			r           <= '0;
			r.mctl      <= {NCMP{MCTL_RST}};
			r.ectl      <= {NCMP{ECTL_RST}};
			r.pos_route <= {NCMP{POS_ROUTE_ONE}};
		end
		else if (ce_in)
			r <= n;
	end

	always_comb
	begin
		s_axi_awready_out = r.awready;
		s_axi_wready_out  = r.wready;
		s_axi_bresp_out   = r.bresp;
		s_axi_bvalid_out  = r.bvalid;
		s_axi_arready_out = r.arready;
		s_axi_rdata_out   = r.rdata;
		s_axi_rresp_out   = r.rresp;
		s_axi_rvalid_out  = r.rvalid;
		cmp_result_out    = r.result;
		pos_route_out     = r.pos_route;
		irq_out           = r.irq;
		for (int i = 0; i < NCMP; i++)
		begin
			cmp_enable_out[i] = r.mctl[i][MCTL_EN_BIT];
			neg_sel_out[i]    = r.ectl[i][NEG_LSB +: 3];
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	// [R1] Rise sets flag 0
	rise_set_a: assert property (ce_in && $past(ce_in) && r.ectl[0][ECTL_RISE_BIT] // [R1]
		&& r.result[0] && !$past(r.result[0]) |=> r.flag[0])
		else $error("rising edge did not set flag 0");

	// [R2] Fall sets flag 1
	fall_set_a: assert property (ce_in && $past(ce_in) && r.ectl[1][ECTL_FALL_BIT] // [R2]
		&& !r.result[1] && $past(r.result[1]) |=> r.flag[1])
		else $error("falling edge did not set flag 1");

	// [R1] No enable, no flag
	no_edge_en_a: assert property (ce_in && !r.flag[0] && !r.ectl[0][ECTL_RISE_BIT] // [R1]
		&& !r.ectl[0][ECTL_FALL_BIT] |=> !r.flag[0])
		else $error("flag 0 set with both edges disabled");

	// [R3] Mirror bit 1
	mirror_bit1_a: assert property (ce_in && s_axi_arvalid_in && r.arready // [R3]
		&& s_axi_araddr_in == ADDR_MIRROR |=> s_axi_rvalid_out && s_axi_rdata_out[1] == $past(r.result[1]))
		else $error("mirror bit 1 differs from result 2");

	// [R4] Mirror bit 0
	mirror_bit0_a: assert property (ce_in && s_axi_arvalid_in && r.arready // [R4]
		&& s_axi_araddr_in == ADDR_MIRROR |=> s_axi_rdata_out[0] == $past(r.result[0]))
		else $error("mirror bit 0 differs from result 1");

	// [R5] Mirror upper zero
	mirror_upper_a: assert property (ce_in && s_axi_arvalid_in && r.arready // [R5]
		&& s_axi_araddr_in == ADDR_MIRROR |=> s_axi_rdata_out[31:2] == 30'h0)
		else $error("mirror upper bits not zero");

	// [R6] Results clear on reset
	reset_zero_a: assert property ($past(rst_in) |-> cmp_result_out == 2'h0) // [R6]
		else $error("result not zero after reset");

	// [R7] Ground route
	pos_route_a: assert property (r.ectl[0][POS_LSB +: 2] == POS_SEL_GND // [R7]
		|-> pos_route_out[0] == 4'h8)
		else $error("ground select not routed");

	// [R8] Set beats clear
	clear_set_wins_a: assert property (ce_in && eif.edge_set[1] |=> r.flag[1]) // [R8]
		else $error("edge lost during flag clear");

	// [R9] Invert toggle edge
	toggle_edge_a: assert property ($changed(r.mctl[0][MCTL_INV_BIT]) && !r.mctl[0][MCTL_EN_BIT] // [R9]
		&& !$past(r.mctl[0][MCTL_EN_BIT]) |-> $changed(r.result[0]))
		else $error("invert toggle did not change result");

	// [R1] Rise sets flag 1
	rise_set1_a: assert property (ce_in && $past(ce_in) && r.ectl[1][ECTL_RISE_BIT] // [R1]
		&& r.result[1] && !$past(r.result[1]) |=> r.flag[1])
		else $error("rising edge did not set flag 1");

	// [R2] Fall sets flag 0
	fall_set0_a: assert property (ce_in && $past(ce_in) && r.ectl[0][ECTL_FALL_BIT] // [R2]
		&& !r.result[0] && $past(r.result[0]) |=> r.flag[0])
		else $error("falling edge did not set flag 0");

	// [R1] Rise ignored when off
	rise_off_a: assert property (ce_in && $past(ce_in) && !r.flag[0] && !r.ectl[0][ECTL_RISE_BIT] // [R1]
		&& r.result[0] && !$past(r.result[0]) |=> !r.flag[0])
		else $error("disabled rising edge set flag 0");

	// [R2] Fall ignored when off
	fall_off_a: assert property (ce_in && $past(ce_in) && !r.flag[1] && !r.ectl[1][ECTL_FALL_BIT] // [R2]
		&& !r.result[1] && $past(r.result[1]) |=> !r.flag[1])
		else $error("disabled falling edge set flag 1");

	// Level interrupt follows unmasked flags with no extra delay
	irq_level_a: assert property (irq_out == |(r.flag & r.mask))
		else $error("interrupt level differs from masked flags");

	// [R7] One route only
	route_onehot_a: assert property ($onehot(pos_route_out[0]) && $onehot(pos_route_out[1])) // [R7]
		else $error("positive route not one-hot");

	// [R7] Pin route
	route_pin_a: assert property (r.ectl[1][POS_LSB +: 2] == POS_SEL_PIN // [R7]
		|-> pos_route_out[1] == 4'h1)
		else $error("pin select not routed");

	// [R7] DAC route
	route_dac_a: assert property (r.ectl[1][POS_LSB +: 2] == POS_SEL_DAC // [R7]
		|-> pos_route_out[1] == 4'h2)
		else $error("dac select not routed");

	// [R7] Vref route
	route_vref_a: assert property (r.ectl[0][POS_LSB +: 2] == POS_SEL_VREF // [R7]
		|-> pos_route_out[0] == 4'h4)
		else $error("vref select not routed");

	// [R7] Ground route two
	route_gnd1_a: assert property (r.ectl[1][POS_LSB +: 2] == POS_SEL_GND // [R7]
		|-> pos_route_out[1] == 4'h8)
		else $error("ground select not routed on comparator 2");

	// [R5] Mirror read legal
	mirror_okay_a: assert property (ce_in && s_axi_arvalid_in && r.arready // [R5]
		&& s_axi_araddr_in == ADDR_MIRROR |=> s_axi_rresp_out == RESP_OKAY)
		else $error("mirror read refused");

	// Clock enable low must hold results and flags, or an edge would be lost
	result_freeze_a: assert property (!ce_in |=> $stable(cmp_result_out) && $stable(r.flag))
		else $error("state moved while clock enable low");

	// Handshakes freeze too, so a slow master sees no lost response
	bus_freeze_a: assert property (!ce_in |=> $stable(s_axi_rvalid_out) && $stable(s_axi_bvalid_out))
		else $error("bus response moved while clock enable low");

endmodule
`default_nettype wire

// ===== cmpei_pkg.sv
// Constants, register map and state type of the comparator edge interrupt block
// Contract
// [R1] Rising enable set: a low-to-high result change sets the interrupt flag; otherwise untouched.
// [R2] Falling enable set: a high-to-low result change sets the flag; both enables may be on.
// [R3] Mirror bit 1 always shows the current result of comparator 2.
// [R4] Mirror bit 0 always shows the current result of comparator 1.
// [R5] Mirror bits 7 to 2 read zero; writes to the mirror do nothing.
// [R6] Both mirror bits read zero after any reset until a result drives them.
// [R7] Positive select routes: 11 ground, 10 fixed vref, 01 DAC, 00 external pin.
// [R8] A qualifying edge in the clearing cycle leaves the flag set.
// [R9] Toggling invert or enable changes the result and counts as an edge; here toggling enable changes the result only while cmp_raw_in is high.
package cmpei_pkg;

	localparam int NCMP = 2;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_MCTL1     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_MCTL2     = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_ECTL1     = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_ECTL2     = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_MIRROR    = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 8'h18;

	// Main control: enable, result (read only), output enable, invert, speed, hysteresis, sync
	localparam int MCTL_EN_BIT  = 7;
	localparam int MCTL_RES_BIT = 6;
	localparam int MCTL_INV_BIT = 4;
	localparam logic [7:0] MCTL_WMASK = 8'hb7;
	localparam logic [7:0] MCTL_RST   = 8'h04;

	// Edge and input control
	localparam int ECTL_RISE_BIT = 7;
	localparam int ECTL_FALL_BIT = 6;
	localparam int POS_LSB       = 4;
	localparam int NEG_LSB       = 0;
	localparam logic [7:0] ECTL_WMASK = 8'hf7;
	localparam logic [7:0] ECTL_RST   = 8'h00;

	localparam logic [1:0] POS_SEL_PIN  = 2'h0;
	localparam logic [1:0] POS_SEL_DAC  = 2'h1;
	localparam logic [1:0] POS_SEL_VREF = 2'h2;
	localparam logic [1:0] POS_SEL_GND  = 2'h3;
	localparam logic [3:0] POS_ROUTE_ONE = 4'h1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic                  aw_got;
		logic                  w_got;
		logic [ADDR_W-1:0]     waddr;
		logic [7:0]            wbyte;
		logic                  wlane;
		logic [NCMP-1:0][7:0]  mctl;
		logic [NCMP-1:0][7:0]  ectl;
		logic [NCMP-1:0]       result;
		logic [NCMP-1:0]       flag;
		logic [NCMP-1:0]       mask;
		logic                  irq;
		logic [NCMP-1:0][3:0]  pos_route;
	} cmpei_state_s;

	typedef struct packed {
		logic [NCMP-1:0] prev;
	} cmpei_edge_state_s;

endpackage

// ===== cmpei_edge_if.sv
// Interface between the register side and the edge detector
`timescale 1ns/1ps
`default_nettype none
interface cmpei_edge_if;
	logic [1:0] result;
	logic [1:0] rise_en;
	logic [1:0] fall_en;
	logic [1:0] edge_set;
	modport ctl (output result, output rise_en, output fall_en, input edge_set);
	modport det (input result, input rise_en, input fall_en, output edge_set);
endinterface
`default_nettype wire

// ===== cmpei_edge.sv
// Per-comparator edge detector feeding the interrupt flags
`timescale 1ns/1ps
`default_nettype none
module cmpei_edge
	import cmpei_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// Edge signals
	cmpei_edge_if.det eif
);
	cmpei_edge_state_s r;
	cmpei_edge_state_s n;

	always_comb
	begin
		n = r;
		n.prev = eif.result;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			r <= '0;
		else if (ce_in)
			r <= n;
	end

	genvar i;
	generate
		for (i = 0; i < NCMP; i++)
		begin : g_ch
			// [R1] [R2] Qualified edges
			assign eif.edge_set[i] = (eif.rise_en[i] & eif.result[i] & ~r.prev[i])
				| (eif.fall_en[i] & ~eif.result[i] & r.prev[i]);
		end
	endgenerate

	edge_only_change_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R1]
		(eif.edge_set != 2'h0) |-> ((eif.result ^ r.prev) & eif.edge_set) == eif.edge_set)
		else $error("edge reported without a result change");

endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the comparator edge interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import cmpei_pkg::*;
;
	logic                  ref_clk_in = 1'h0;
	logic                  rst_in = 1'h1;
	logic                  ce = 1'h1;
	logic [3:0]            wstrb = 4'h1;
	logic [ADDR_W-1:0]     awaddr = 8'h0;
	logic [ADDR_W-1:0]     araddr = 8'h0;
	logic [31:0]           wdata = 32'h0;
	logic                  awvalid = 1'h0;
	logic                  wvalid = 1'h0;
	logic                  bready = 1'h0;
	logic                  arvalid = 1'h0;
	logic                  rready = 1'h0;
	logic [NCMP-1:0]       raw = 2'h0;
	logic                  awready;
	logic                  wready;
	logic                  bvalid;
	logic                  arready;
	logic                  rvalid;
	logic [1:0]            bresp;
	logic [1:0]            rresp;
	logic [31:0]           rdata;
	logic [NCMP-1:0]       res;
	logic [NCMP-1:0]       en;
	logic [NCMP-1:0][3:0]  route;
	logic [NCMP-1:0][2:0]  negsel;
	logic                  irq;
	int                    err_count = 0;
	int                    check_count = 0;

	cmpei_top u_cmpei_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.cmp_raw_in(raw), .cmp_result_out(res), .cmp_enable_out(en), .pos_route_out(route),
		.neg_sel_out(negsel), .irq_out(irq));

	always #2.5 ref_clk_in = ~ref_clk_in;

	task automatic close_out;
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Ready is a register, so the level at the falling edge is what the next rising edge samples
	task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic tb;
		logic sa;
		logic sw;
		logic [1:0] r;
		tb = 1'h0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 40 && !tb; n++)
		begin
			@(negedge ref_clk_in);
			tb = bvalid;
			r = bresp;
			sa = awready;
			sw = wready;
			@(posedge ref_clk_in);
			if (sa)
				awvalid <= 1'h0;
			if (sw)
				wvalid <= 1'h0;
		end
		bready <= 1'h0;
		@(posedge ref_clk_in);
		if (!tb)
		begin
			err_count++;
			close_out;
		end
		chk(32'(r), 32'(er));
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic tr;
		logic sa;
		logic [31:0] d;
		logic [1:0] r;
		tr = 1'h0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 40 && !tr; n++)
		begin
			@(negedge ref_clk_in);
			tr = rvalid;
			d = rdata;
			r = rresp;
			sa = arready;
			@(posedge ref_clk_in);
			if (sa)
				arvalid <= 1'h0;
		end
		rready <= 1'h0;
		@(posedge ref_clk_in);
		if (!tr)
		begin
			err_count++;
			close_out;
		end
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	task automatic t_reset;
		rchk(ADDR_MIRROR, 32'h0, RESP_OKAY);
		rchk(ADDR_ECTL1, 32'h0, RESP_OKAY);
		rchk(ADDR_ECTL2, 32'h0, RESP_OKAY);
		chk(32'(irq), 32'h0);
	endtask

	task automatic t_route;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 4; i++)
			begin
				wchk(c ? ADDR_ECTL2 : ADDR_ECTL1, 8'(i << POS_LSB) | 8'h5, RESP_OKAY);
				chk(32'(route[c]), 32'(POS_ROUTE_ONE << i));
				chk(32'(negsel[c]), 32'h5);
			end
	endtask

	// Every enable combination on both comparators, mask open so the level output follows
	task automatic t_edges;
		wchk(ADDR_IRQ_MASK, 8'h3, RESP_OKAY);
		wchk(ADDR_MCTL1, 8'h80, RESP_OKAY);
		wchk(ADDR_MCTL2, 8'h80, RESP_OKAY);
		chk(32'(en), 32'h3);
		for (int c = 0; c < 2; c++)
			for (int m = 0; m < 4; m++)
			begin
				wchk(c ? ADDR_ECTL2 : ADDR_ECTL1, 8'(m << 6), RESP_OKAY);
				raw <= 2'(1 << c);
				repeat (4) @(posedge ref_clk_in);
				rchk(ADDR_MIRROR, 32'(1 << c), RESP_OKAY);
				rchk(ADDR_IRQ_STAT, 32'(m[1]) << c, RESP_OKAY);
				chk(32'(irq), 32'(m[1]));
				wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
				raw <= 2'h0;
				repeat (4) @(posedge ref_clk_in);
				rchk(ADDR_IRQ_STAT, 32'(m[0]) << c, RESP_OKAY);
				wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
			end
	endtask

	task automatic t_mirror;
		raw <= 2'h3;
		repeat (4) @(posedge ref_clk_in);
		chk(32'(res), 32'h3);
		wchk(ADDR_MIRROR, 8'hff, RESP_OKAY);
		rchk(ADDR_MIRROR, 32'h3, RESP_OKAY);
		wchk(8'h40, 8'h1, RESP_SLVERR);
		rchk(8'h40, 32'h0, RESP_SLVERR);
		wstrb <= 4'h0;
		wchk(ADDR_IRQ_MASK, 8'h0, RESP_OKAY);
		wstrb <= 4'h1;
		rchk(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
		raw <= 2'h0;
		repeat (4) @(posedge ref_clk_in);
	endtask

	// Comparator 1 is switched off, so only invert and enable can move the result
	task automatic t_toggle;
		wchk(ADDR_MCTL1, 8'h00, RESP_OKAY);
		wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
		wchk(ADDR_MCTL1, 8'h10, RESP_OKAY);
		rchk(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
		wchk(ADDR_MCTL1, 8'h00, RESP_OKAY);
		wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
		raw <= 2'h1;
		wchk(ADDR_MCTL1, 8'h80, RESP_OKAY);
		rchk(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
		wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
	endtask

	// Edge lands on the clearing write's edge: raw moves one edge before the write is offered
	task automatic t_race;
		raw <= 2'h0;
		@(posedge ref_clk_in);
		wchk(ADDR_IRQ_STAT, 8'h1, RESP_OKAY);
		rchk(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
	endtask

	// Clock enable low freezes results and flags; the edge shows once it is high again
	task automatic t_freeze;
		wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
		ce <= 1'h0;
		raw <= 2'h3;
		repeat (4) @(posedge ref_clk_in);
		chk(32'(res), 32'h0);
		chk(32'(irq), 32'h0);
		ce <= 1'h1;
		repeat (4) @(posedge ref_clk_in);
		chk(32'(res), 32'h3);
		chk(32'(irq), 32'h1);
		rchk(ADDR_IRQ_STAT, 32'h3, RESP_OKAY);
		wchk(ADDR_IRQ_STAT, 8'h3, RESP_OKAY);
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		@(posedge ref_clk_in);
		t_reset;
		t_route;
		t_edges;
		t_mirror;
		t_toggle;
		t_race;
		t_freeze;
		close_out;
	end
endmodule
`default_nettype wire
